// [hw/ets_pkg.sv]
`default_nettype none
package ets_pkg;

  localparam int ETS_CW = 4;
  localparam int ETS_TW = 10;

  // Category indices, in the order the sequencer walks them
  localparam logic [2:0] ETS_CAT_FETCH = 3'h0;
  localparam logic [2:0] ETS_CAT_BRRD  = 3'h1;
  localparam logic [2:0] ETS_CAT_STACK = 3'h2;
  localparam logic [2:0] ETS_CAT_BYTE  = 3'h3;
  localparam logic [2:0] ETS_CAT_WORD  = 3'h4;
  localparam logic [2:0] ETS_CAT_INTOP = 3'h5;
  localparam logic [2:0] ETS_CAT_NONE  = 3'h7;

  // States per cycle
  localparam logic [1:0] ETS_COST_MEM       = 2'h2;
  localparam logic [1:0] ETS_COST_PERI_FAST = 2'h2;
  localparam logic [1:0] ETS_COST_PERI_SLOW = 2'h3;
  localparam logic [1:0] ETS_COST_INTOP     = 2'h1;

  typedef enum logic [4:0] {
    ETS_OP_ADD_B_IMM = 5'h00,
    ETS_OP_ADD_B_REG = 5'h01,
    ETS_OP_ADD_W_IMM = 5'h02,
    ETS_OP_ADD_W_REG = 5'h03,
    ETS_OP_ADD_L_IMM = 5'h04,
    ETS_OP_ADD_L_REG = 5'h05,
    ETS_OP_ADDS      = 5'h06,
    ETS_OP_ADDX_IMM  = 5'h07,
    ETS_OP_ADDX_REG  = 5'h08,
    ETS_OP_AND_B_IMM = 5'h09,
    ETS_OP_AND_B_REG = 5'h0A,
    ETS_OP_AND_W_IMM = 5'h0B,
    ETS_OP_AND_W_REG = 5'h0C,
    ETS_OP_AND_L_IMM = 5'h0D,
    ETS_OP_AND_L_REG = 5'h0E,
    ETS_OP_ANDC      = 5'h0F,
    ETS_OP_BAND_REG  = 5'h10,
    ETS_OP_BAND_IND  = 5'h11,
    ETS_OP_BAND_ABS  = 5'h12,
    ETS_OP_BCC_D8    = 5'h13,
    ETS_OP_BSET_ABS  = 5'h14,
    ETS_OP_JSR_MIND  = 5'h15
  } ets_op_e;

  // Counts packed as {N,M,L,K,J,I}, four bits each
  typedef logic [5:0][ETS_CW-1:0] ets_cnt_t;

  function automatic ets_cnt_t ets_mk(input int i, input int j, input int k,
                                      input int l, input int m, input int n);
    ets_cnt_t c;
    c[0] = ETS_CW'(i);
    c[1] = ETS_CW'(j);
    c[2] = ETS_CW'(k);
    c[3] = ETS_CW'(l);
    c[4] = ETS_CW'(m);
    c[5] = ETS_CW'(n);
    return c;
  endfunction : ets_mk

  function automatic ets_cnt_t ets_lookup(input ets_op_e op);
    ets_cnt_t c;
    c = '0;
    case (op)
      ETS_OP_ADD_W_IMM, ETS_OP_AND_W_IMM,
      ETS_OP_AND_L_REG, ETS_OP_BCC_D8:        c = ets_mk(2, 0, 0, 0, 0, 0);
      ETS_OP_ADD_L_IMM, ETS_OP_AND_L_IMM:     c = ets_mk(3, 0, 0, 0, 0, 0);
      ETS_OP_BAND_IND, ETS_OP_BAND_ABS:       c = ets_mk(2, 0, 0, 1, 0, 0);
      ETS_OP_BSET_ABS:                        c = ets_mk(2, 0, 0, 2, 0, 0);
      ETS_OP_JSR_MIND:                        c = ets_mk(2, 1, 1, 0, 0, 0);
      default:                                c = ets_mk(1, 0, 0, 0, 0, 0);
    endcase
    return c;
  endfunction : ets_lookup

endpackage : ets_pkg
`default_nettype wire

// [hw/ets_timing.sv]
`default_nettype none
module ets_timing
  import ets_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  // Instruction request
  input  wire logic              start,
  input  wire logic [4:0]        opSel,
  input  wire logic              useExplicit,
  input  wire logic [23:0]       explicitCnt,
  // Access location of data cycles
  input  wire logic              dataToPeriph,
  input  wire logic              periphSlow,
  // Sequencer status
  output var  logic              busy_reg,
  output var  logic              cycleStart_reg,
  output var  logic [2:0]        category_reg,
  output var  logic              done_reg,
  output var  logic [ETS_TW-1:0] totalStates_reg
);

  ets_cnt_t         reqCnt;
  logic [5:0][1:0]  reqCost;
  logic [ETS_TW-1:0] reqTotal;
  logic [2:0]       reqFirst;
  ets_cnt_t         cnt_reg;
  logic [5:0][1:0]  cost_reg;
  logic [ETS_CW-1:0] cycLeft_reg;
  logic [1:0]       stLeft_reg;
  logic [2:0]       nextCat;
  logic             accept;
  logic             lastState;

  // Lowest category at or above 'from' with a nonzero count
  function automatic logic [2:0] firstFrom(input ets_cnt_t c, input logic [2:0] from);
    logic [2:0] r;
    r = ETS_CAT_NONE;
    for (int i = 5; i >= 0; i--) begin
      if (3'(i) >= from && c[i] != '0) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : firstFrom

  assign accept = start && !busy_reg;
  assign lastState = busy_reg && stLeft_reg == 2'h1 && cycLeft_reg == ETS_CW'(1);
  assign nextCat = firstFrom(cnt_reg, category_reg + 3'h1);

  // Counts per category come from the form table or straight from the caller
  always_comb begin
    reqCnt = useExplicit ? ets_cnt_t'(explicitCnt) : ets_lookup(ets_op_e'(opSel));
  end

  always_comb begin
    reqCost[0] = ETS_COST_MEM;
    reqCost[1] = ETS_COST_MEM;
    reqCost[2] = ETS_COST_MEM;
    reqCost[3] = !dataToPeriph ? ETS_COST_MEM :
                 (periphSlow ? ETS_COST_PERI_SLOW : ETS_COST_PERI_FAST);
    reqCost[4] = reqCost[3];
    reqCost[5] = ETS_COST_INTOP;
  end

  // Zero counts multiply to nothing, so they add no states
  always_comb begin
    reqTotal = '0;
    for (int i = 0; i < 6; i++) begin
      reqTotal = reqTotal + ETS_TW'(reqCnt[i]) * ETS_TW'(reqCost[i]);
    end
    reqFirst = firstFrom(reqCnt, ETS_CAT_FETCH);
  end

  // Latch the request; a start while busy is ignored
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg         <= '0;
      cost_reg        <= '0;
      totalStates_reg <= '0;
    end else if (accept) begin
      cnt_reg         <= reqCnt;
      cost_reg        <= reqCost;
      totalStates_reg <= reqTotal;
    end
  end

  // One state per clock; categories are walked in order, empty ones skipped
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_reg       <= 1'b0;
      cycleStart_reg <= 1'b0;
      category_reg   <= ETS_CAT_NONE;
      cycLeft_reg    <= '0;
      stLeft_reg     <= '0;
    end else if (accept) begin
      busy_reg       <= reqFirst != ETS_CAT_NONE;
      cycleStart_reg <= reqFirst != ETS_CAT_NONE;
      category_reg   <= reqFirst;
      cycLeft_reg    <= reqFirst == ETS_CAT_NONE ? '0 : reqCnt[reqFirst];
      stLeft_reg     <= reqFirst == ETS_CAT_NONE ? '0 : reqCost[reqFirst];
    end else if (busy_reg) begin
      if (stLeft_reg != 2'h1) begin
        stLeft_reg     <= stLeft_reg - 2'h1;
        cycleStart_reg <= 1'b0;
      end else if (cycLeft_reg != ETS_CW'(1)) begin
        cycLeft_reg    <= cycLeft_reg - ETS_CW'(1);
        stLeft_reg     <= cost_reg[category_reg];
        cycleStart_reg <= 1'b1;
      end else if (nextCat != ETS_CAT_NONE) begin
        category_reg   <= nextCat;
        cycLeft_reg    <= cnt_reg[nextCat];
        stLeft_reg     <= cost_reg[nextCat];
        cycleStart_reg <= 1'b1;
      end else begin
        busy_reg       <= 1'b0;
        cycleStart_reg <= 1'b0;
        category_reg   <= ETS_CAT_NONE;
        cycLeft_reg    <= '0;
        stLeft_reg     <= '0;
      end
    end
  end

  // Done also fires for an all-zero request, one cycle after it is taken
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (lastState && nextCat == ETS_CAT_NONE) ||
                  (accept && reqFirst == ETS_CAT_NONE);
    end
  end

  // Checking helpers: states spent and what was requested
  logic [ETS_TW-1:0] spent_reg;
  logic [4:0]        opSeen_reg;
  logic              explSeen_reg;
  logic              periSeen_reg;
  logic              slowSeen_reg;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      spent_reg    <= '0;
      opSeen_reg   <= '0;
      explSeen_reg <= 1'b0;
      periSeen_reg <= 1'b0;
      slowSeen_reg <= 1'b0;
    end else if (accept) begin
      spent_reg    <= '0;
      opSeen_reg   <= opSel;
      explSeen_reg <= useExplicit;
      periSeen_reg <= dataToPeriph;
      slowSeen_reg <= periphSlow;
    end else if (busy_reg) begin
      spent_reg <= spent_reg + ETS_TW'(1);
    end
  end

  sequence s_twoState;
    !cycleStart_reg ##1 (cycleStart_reg || !busy_reg);
  endsequence

  sequence s_threeState;
    !cycleStart_reg ##1 !cycleStart_reg ##1 (cycleStart_reg || !busy_reg);
  endsequence

  property p_total;
    @(posedge ref_clk) disable iff (!arst_n)
      done_reg |-> spent_reg == totalStates_reg;
  endproperty
  a_total: assert property (p_total) else $error("state total mismatch");

  property p_counts;
    @(posedge ref_clk) disable iff (!arst_n)
      accept && useExplicit |=> cnt_reg == ets_cnt_t'($past(explicitCnt));
  endproperty
  a_counts: assert property (p_counts) else $error("counts not latched");

  property p_fetch;
    @(posedge ref_clk) disable iff (!arst_n)
      cycleStart_reg && category_reg == ETS_CAT_FETCH |=> s_twoState;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not two states");

  property p_byteMem;
    @(posedge ref_clk) disable iff (!arst_n)
      cycleStart_reg && category_reg == ETS_CAT_BYTE && !periSeen_reg |=> s_twoState;
  endproperty
  a_byteMem: assert property (p_byteMem) else $error("RAM byte not two states");

  property p_brStack;
    @(posedge ref_clk) disable iff (!arst_n)
      cycleStart_reg && (category_reg == ETS_CAT_BRRD || category_reg == ETS_CAT_STACK)
      |=> s_twoState;
  endproperty
  a_brStack: assert property (p_brStack) else $error("branch/stack not two");

  property p_periph;
    @(posedge ref_clk) disable iff (!arst_n)
      cycleStart_reg && (category_reg == ETS_CAT_BYTE || category_reg == ETS_CAT_WORD)
      && periSeen_reg && !slowSeen_reg |=> s_twoState;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral cost wrong");

  property p_periphSlow;
    @(posedge ref_clk) disable iff (!arst_n)
      cycleStart_reg && (category_reg == ETS_CAT_BYTE || category_reg == ETS_CAT_WORD)
      && periSeen_reg && slowSeen_reg |=> s_threeState;
  endproperty
  a_periphSlow: assert property (p_periphSlow) else $error("slow peripheral not three");

  property p_addL;
    @(posedge ref_clk) disable iff (!arst_n)
      accept && !useExplicit && opSel == ETS_OP_ADD_L_IMM |=> totalStates_reg == 10'h006;
  endproperty
  a_addL: assert property (p_addL) else $error("long add immediate total");

  property p_andW;
    @(posedge ref_clk) disable iff (!arst_n)
      accept && !useExplicit && opSel == ETS_OP_AND_W_IMM |=> totalStates_reg == 10'h004;
  endproperty
  a_andW: assert property (p_andW) else $error("word AND immediate total");

  property p_band;
    @(posedge ref_clk) disable iff (!arst_n)
      done_reg && !explSeen_reg && opSeen_reg == ETS_OP_BAND_IND && !periSeen_reg
      |-> totalStates_reg == 10'h006;
  endproperty
  a_band: assert property (p_band) else $error("bit-AND memory total");

  property p_bcc;
    @(posedge ref_clk) disable iff (!arst_n)
      accept && !useExplicit && opSel == ETS_OP_BCC_D8 |=> busy_reg [*4] ##1 done_reg;
  endproperty
  a_bcc: assert property (p_bcc) else $error("short branch not four states");

  property p_intop;
    @(posedge ref_clk) disable iff (!arst_n)
      cycleStart_reg && category_reg == ETS_CAT_INTOP |=> (cycleStart_reg || !busy_reg);
  endproperty
  a_intop: assert property (p_intop) else $error("internal op not one state");

  property p_addLReg;
    @(posedge ref_clk) disable iff (!arst_n)
      accept && !useExplicit && opSel == ETS_OP_ADD_L_REG |=> totalStates_reg == 10'h002;
  endproperty
  a_addLReg: assert property (p_addLReg) else $error("long add register total");

  property p_andL;
    @(posedge ref_clk) disable iff (!arst_n)
      accept && !useExplicit && opSel == ETS_OP_AND_L_IMM |=> totalStates_reg == 10'h006;
  endproperty
  a_andL: assert property (p_andL) else $error("long AND immediate total");

  property p_andB;
    @(posedge ref_clk) disable iff (!arst_n)
      accept && !useExplicit && (opSel == ETS_OP_AND_B_IMM || opSel == ETS_OP_AND_B_REG)
      |=> totalStates_reg == 10'h002;
  endproperty
  a_andB: assert property (p_andB) else $error("byte AND total");

  property p_bandReg;
    @(posedge ref_clk) disable iff (!arst_n)
      accept && !useExplicit && opSel == ETS_OP_BAND_REG |=> totalStates_reg == 10'h002;
  endproperty
  a_bandReg: assert property (p_bandReg) else $error("bit-AND register total");

  property p_bandAbs;
    @(posedge ref_clk) disable iff (!arst_n)
      done_reg && !explSeen_reg && opSeen_reg == ETS_OP_BAND_ABS
      |-> totalStates_reg == (periSeen_reg && slowSeen_reg ? 10'h007 : 10'h006);
  endproperty
  a_bandAbs: assert property (p_bandAbs) else $error("bit-AND absolute total");

  property p_bccFetch;
    @(posedge ref_clk) disable iff (!arst_n)
      busy_reg && !explSeen_reg && opSeen_reg == ETS_OP_BCC_D8
      |-> category_reg == ETS_CAT_FETCH;
  endproperty
  a_bccFetch: assert property (p_bccFetch) else $error("short branch left fetch");

  property p_zero;
    @(posedge ref_clk) disable iff (!arst_n)
      accept && useExplicit && explicitCnt == 24'h000000
      |=> !busy_reg && done_reg && totalStates_reg == 10'h000;
  endproperty
  a_zero: assert property (p_zero) else $error("empty request took states");

  property p_idle;
    @(posedge ref_clk) disable iff (!arst_n)
      !busy_reg |-> !cycleStart_reg && category_reg == ETS_CAT_NONE;
  endproperty
  a_idle: assert property (p_idle) else $error("cycle shown while idle");

  property p_doneIdle;
    @(posedge ref_clk) disable iff (!arst_n)
      done_reg |-> !busy_reg;
  endproperty
  a_doneIdle: assert property (p_doneIdle) else $error("done while busy");

  property p_bset;
    @(posedge ref_clk) disable iff (!arst_n)
      accept && !useExplicit && opSel == ETS_OP_BSET_ABS && !dataToPeriph
      |=> totalStates_reg == 10'h008;
  endproperty
  a_bset: assert property (p_bset) else $error("bit-set RAM total");

  property p_jsr;
    @(posedge ref_clk) disable iff (!arst_n)
      accept && !useExplicit && opSel == ETS_OP_JSR_MIND |=> totalStates_reg == 10'h008;
  endproperty
  a_jsr: assert property (p_jsr) else $error("indirect call total");

endmodule : ets_timing
`default_nettype wire

// [bench/ets_periph_model.sv]
`default_nettype none
module ets_periph_model (
  // Location chosen by the bench
  input  wire logic       selPeriph,
  input  wire logic [1:0] modIdx,
  // Location seen by the sequencer
  output var  logic       dataToPeriph,
  output var  logic       periphSlow
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wait states are fixed per module, so the speed follows bit 0 of the index only
  assign dataToPeriph = selPeriph;
  assign periphSlow   = selPeriph & modIdx[0];
endmodule : ets_periph_model
`default_nettype wire

// [bench/tb.sv]
`default_nettype none
module tb
  import ets_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              ref_clk = 1'b0;
  logic              arst_n;
  logic              start;
  logic [4:0]        opSel;
  logic              useExplicit;
  logic [23:0]       explicitCnt;
  logic              selPeriph;
  logic [1:0]        modIdx;
  logic              toPeriph;
  logic              slowPeriph;
  logic              busy;
  logic              cycStart;
  logic [2:0]        cat;
  logic              done;
  logic [ETS_TW-1:0] total;
  int                mismatches = 0;
  int                checks_done = 0;

  always #50 ref_clk = ~ref_clk;

  ets_timing u_dut (
    .ref_clk        (ref_clk),
    .arst_n         (arst_n),
    .start          (start),
    .opSel          (opSel),
    .useExplicit    (useExplicit),
    .explicitCnt    (explicitCnt),
    .dataToPeriph   (toPeriph),
    .periphSlow     (slowPeriph),
    .busy_reg       (busy),
    .cycleStart_reg (cycStart),
    .category_reg   (cat),
    .done_reg       (done),
    .totalStates_reg(total)
  );

  ets_periph_model u_loc (
    .selPeriph   (selPeriph),
    .modIdx      (modIdx),
    .dataToPeriph(toPeriph),
    .periphSlow  (slowPeriph)
  );

  task automatic end_sim();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic tick();
    @(posedge ref_clk);
    #5;
  endtask : tick

  task automatic setup(input ets_op_e op, input logic ue, input logic [23:0] cnt,
                       input logic sp, input logic [1:0] mi);
    opSel = op;
    useExplicit = ue;
    explicitCnt = cnt;
    selPeriph = sp;
    modIdx = mi;
    start = 1'b1;
  endtask : setup

  // cnt always holds the expected counts, also when the table is used
  task automatic run_op(input ets_op_e op, input logic ue, input logic [23:0] cnt,
                        input logic sp, input logic [1:0] mi);
    int n;
    int cs;
    int nc;
    int expT;
    int ec;
    int rem [6];
    logic [1:0] dc;
    n = 0;
    cs = 0;
    nc = 0;
    expT = 0;
    dc = !sp ? ETS_COST_MEM : mi[0] ? ETS_COST_PERI_SLOW : ETS_COST_PERI_FAST;
    for (int i = 0; i < 6; i++) begin
      rem[i] = cnt[i*4 +: 4];
      nc += cnt[i*4 +: 4];
      expT += cnt[i*4 +: 4] * (i == 5 ? ETS_COST_INTOP : i > 2 ? dc : ETS_COST_MEM);
    end
    setup(op, ue, cnt, sp, mi);
    tick();
    start = 1'b0;
    check(total, expT);
    while (busy === 1'b1 && n < 1000) begin
      if (cycStart === 1'b1) begin
        cs++;
        ec = 0;
        while (ec < 5 && rem[ec] == 0) begin
          ec++;
        end
        rem[ec]--;
        check(cat, ec);
      end
      n++;
      tick();
    end
    if (n >= 1000) begin
      mismatches++;
      end_sim();
    end
    check(n, expT);
    check(cs, nc);
    check(done, 1);
    check(cat, ETS_CAT_NONE);
  endtask : run_op

  task automatic t_branch();
    run_op(ETS_OP_BCC_D8, 1'b0, 24'h000002, 1'b0, 2'h0);
    run_op(ETS_OP_BCC_D8, 1'b0, 24'h000002, 1'b1, 2'h1);
  endtask : t_branch

  task automatic t_long();
    run_op(ETS_OP_ADD_L_IMM, 1'b0, 24'h000003, 1'b0, 2'h0);
    run_op(ETS_OP_ADD_L_REG, 1'b0, 24'h000001, 1'b0, 2'h0);
    run_op(ETS_OP_ADD_W_IMM, 1'b0, 24'h000002, 1'b0, 2'h0);
    run_op(ETS_OP_AND_L_REG, 1'b0, 24'h000002, 1'b0, 2'h0);
    run_op(ETS_OP_AND_L_IMM, 1'b0, 24'h000003, 1'b0, 2'h0);
    run_op(ETS_OP_AND_W_IMM, 1'b0, 24'h000002, 1'b0, 2'h0);
    run_op(ETS_OP_AND_B_IMM, 1'b0, 24'h000001, 1'b0, 2'h0);
    run_op(ETS_OP_AND_B_REG, 1'b0, 24'h000001, 1'b0, 2'h0);
  endtask : t_long

  task automatic t_bitand();
    run_op(ETS_OP_BAND_IND, 1'b0, 24'h001002, 1'b0, 2'h0);
    run_op(ETS_OP_BAND_ABS, 1'b0, 24'h001002, 1'b1, 2'h3);
    run_op(ETS_OP_BAND_REG, 1'b0, 24'h000001, 1'b1, 2'h3);
    run_op(ETS_OP_BSET_ABS, 1'b0, 24'h002002, 1'b0, 2'h0);
    run_op(ETS_OP_JSR_MIND, 1'b0, 24'h000112, 1'b0, 2'h0);
  endtask : t_bitand

  task automatic t_explicit();
    run_op(ETS_OP_ADDS, 1'b1, 24'h311111, 1'b1, 2'h1);
    run_op(ETS_OP_ADDS, 1'b1, 24'h011111, 1'b1, 2'h2);
    run_op(ETS_OP_ADDS, 1'b1, 24'h000000, 1'b0, 2'h0);
    run_op(ETS_OP_ADDS, 1'b1, 24'h300000, 1'b1, 2'h1);
    run_op(ETS_OP_ADDS, 1'b1, 24'h020000, 1'b0, 2'h0);
  endtask : t_explicit

  // A second request while busy must leave the running count alone
  task automatic t_refuse();
    setup(ETS_OP_ADD_L_IMM, 1'b0, 24'h0, 1'b0, 2'h0);
    tick();
    opSel = ETS_OP_BCC_D8;
    tick();
    start = 1'b0;
    check(total, 6);
    for (int i = 0; i < 8 && done !== 1'b1; i++) begin
      tick();
    end
    check(done, 1);
    check(total, 6);
  endtask : t_refuse

  initial begin
    arst_n = 1'b0;
    start = 1'b0;
    opSel = ETS_OP_ADDS;
    useExplicit = 1'b0;
    explicitCnt = 24'h0;
    selPeriph = 1'b0;
    modIdx = 2'h0;
    repeat (6) @(posedge ref_clk);
    #5;
    arst_n = 1'b1;
    check({busy, cat, done, total}, {1'b0, ETS_CAT_NONE, 1'b0, 10'h000});
    t_branch();
    t_long();
    t_bitand();
    t_explicit();
    t_refuse();
    end_sim();
  end
endmodule : tb
`default_nettype wire
